// [rtl/arc_pkg.sv]
// Purpose: shared constants for the converter register interface
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes:   offsets and timing counts named once here
package arc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [4:0] OFS_RES_LO = 5'h00;
  localparam logic [4:0] OFS_RES_HI = 5'h04;
  localparam logic [4:0] OFS_CTL0   = 5'h08;
  localparam logic [4:0] OFS_CTL1   = 5'h0C;
  localparam logic [4:0] OFS_CTL2   = 5'h10;
  localparam logic [4:0] OFS_BGAP   = 5'h14;
  // ==========================================================
  // field positions
  localparam int BIT_START   = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_EN      = 5;
  localparam int BIT_ALIGN   = 4;
  localparam int BIT_PGA_EN  = 7;
  localparam int BIT_PGA_IS  = 4;
  localparam int BIT_BGAP_EN = 0;
  // ==========================================================
  // writable masks and reset values
  localparam logic [7:0] MSK_CTL0   = 8'h3F;
  localparam logic [7:0] MSK_CTL1   = 8'hF7;
  localparam logic [7:0] MSK_CTL2   = 8'h9F;
  localparam logic [7:0] MSK_BGAP   = 8'h01;
  localparam logic [7:0] RST_CTL0   = 8'h00;
  localparam logic [7:0] RST_CTL1   = 8'h00;
  localparam logic [7:0] RST_CTL2   = 8'h00;
  localparam logic [7:0] RST_BGAP   = 8'h00;
  localparam logic [11:0] RST_RES   = 12'h000;
  // ==========================================================
  // signal source codes: 0 selects the external channel
  localparam logic [3:0] SRC_EXT    = 4'h0;
  // ==========================================================
  // conversion timing
  localparam int  CONV_BITS         = 12;
  localparam logic [7:0] CLK_DIV_BASE = 8'h02;
  // ==========================================================
  // functions
  function automatic logic [15:0] align_result(input logic [11:0] r, input logic right);
    align_result = right ? {4'h0, r} : {r, 4'h0};
  endfunction
endpackage

// [rtl/arc_sar.sv]
// Purpose: successive-approximation sequencer, one bit per enable
// Assumes: comparator sampled on the converter clock enable
// Notes:   result presented only on completion
`timescale 1ns/1ps
`default_nettype none
module arc_sar
  import arc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // control
  input  wire logic        tick,
  input  wire logic        go,
  input  wire logic        cmp_hi,
  // status and data
  output logic             busy_ff,
  output logic             done_ff,
  output logic [11:0]      trial_ff,
  output logic [11:0]      res_ff
);
  // ==========================================================
  // state
  logic [3:0]  bit_ff;
  wire  [11:0] one_hot = 12'h001 << bit_ff;
  wire  [11:0] kept    = cmp_hi ? trial_ff : (trial_ff & ~one_hot);
  wire         last    = (bit_ff == 4'h0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      bit_ff   <= 4'h0;
      trial_ff <= 12'h000;
      res_ff   <= RST_RES;
    end else begin
      done_ff <= 1'b0;
      if (go && !busy_ff) begin
        busy_ff  <= 1'b1;
        bit_ff   <= 4'(CONV_BITS - 1);
        trial_ff <= 12'h800;
      end else if (busy_ff && tick) begin
        if (last) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          res_ff  <= kept; // RL16
        end else begin
          bit_ff   <= bit_ff - 4'h1;
          trial_ff <= kept | (one_hot >> 1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/arc_top.sv]
// Purpose: register interface of a 12-bit SAR converter
// Assumes: Avalon-MM slave, 32-bit words, 8-bit registers
// Notes:   analog front end is outside; selections and the dac_trial code leave here
//
// Overview of operation
// RL1 - read-only 12-bit result in two bytes
// RL2 - align bit selects left or right result
// RL3 - unused result bits read zero
// RL4 - disabled converter keeps result unchanged
// RL5 - start at bit 7, busy at 6
// RL6 - external channel select in bits 3:0
// RL7 - clock select bits 2:0, bit 3 unused
// RL8 - signal source select in bits 7:4
// RL9 - one multiplexer feeds the single converter
// RL10 - gain amplifier fields in third control register
// RL11 - bandgap enable at bit 0 only
// RL12 - analog pin loses digital functions
// RL13 - analog pin loses pull-high resistor
// RL14 - internal source disconnects external channel
// RL15 - busy high from start until result
// RL16 - result updates only at completion
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module arc_top
  import arc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // analog side
  input  wire logic        cmp_in,
  input  wire logic [15:0] pin_analog_sel,
  output logic [11:0]      dac_trial,
  output logic [15:0]      mux_ext_onehot,
  output logic [3:0]       mux_int_sel,
  output logic             mux_ext_on,
  output logic [15:0]      pin_digital_off,
  output logic [15:0]      pin_pullhigh_off,
  output logic             pga_enable,
  output logic             pga_input_sel,
  output logic [1:0]       ref_sel,
  output logic [1:0]       pga_gain_sel,
  output logic             bgap_enable
);
  // ==========================================================
  // registers
  logic [7:0]  ctl0_ff;
  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [7:0]  bgap_ff;
  logic [11:0] res_ff;
  logic        ack_ff;
  logic        start_ff;
  logic [7:0]  div_ff;
  logic        tick_ff;
  logic        cmp_s1_ff;
  logic        cmp_s2_ff;
  logic [15:0] pin_s1_ff;
  logic [15:0] pin_s2_ff;
  logic        sar_busy;
  logic        sar_done;
  logic [11:0] sar_trial;
  logic [11:0] sar_res;

  // ==========================================================
  // field decode
  wire        en         = ctl0_ff[BIT_EN];
  wire        align_rt   = ctl0_ff[BIT_ALIGN];
  wire [3:0]  fld_chan   = ctl0_ff[3:0]; // RL6
  wire [2:0]  fld_clk    = ctl1_ff[2:0]; // RL7
  wire [3:0]  fld_src    = ctl1_ff[7:4]; // RL8
  wire        fld_pga_en = ctl2_ff[BIT_PGA_EN]; // RL10
  wire        fld_pga_is = ctl2_ff[BIT_PGA_IS];
  wire [1:0]  fld_ref    = ctl2_ff[3:2];
  wire [1:0]  fld_gain   = ctl2_ff[1:0];
  wire        fld_bgap   = bgap_ff[BIT_BGAP_EN]; // RL11

  // ==========================================================
  // bus decode
  wire        req      = avs_read | avs_write;
  wire        wr_go    = avs_write & ack_ff & avs_byteenable[0];
  wire        hit_ctl0 = (avs_address == OFS_CTL0);
  wire        hit_ctl1 = (avs_address == OFS_CTL1);
  wire        hit_ctl2 = (avs_address == OFS_CTL2);
  wire        hit_bgap = (avs_address == OFS_BGAP);
  wire        hit_rlo  = (avs_address == OFS_RES_LO);
  wire        hit_rhi  = (avs_address == OFS_RES_HI);
  wire        mapped   = hit_ctl0 | hit_ctl1 | hit_ctl2 | hit_bgap | hit_rlo | hit_rhi;
  wire [7:0]  wdat     = avs_writedata[7:0];
  wire [15:0] res_view = align_result(res_ff, align_rt); // RL2 RL3
  wire [7:0]  ctl0_rd  = {start_ff, sar_busy, ctl0_ff[5:0]}; // RL5 RL15
  wire [7:0]  rd_byte  = hit_rlo  ? res_view[7:0]  :
                         hit_rhi  ? res_view[15:8] :
                         hit_ctl0 ? ctl0_rd        :
                         hit_ctl1 ? ctl1_ff        :
                         hit_ctl2 ? ctl2_ff        :
                         hit_bgap ? bgap_ff        : 8'h00;
  wire        start_fall = start_ff & wr_go & hit_ctl0 & ~wdat[BIT_START];
  wire        conv_go    = start_fall & en & ~sar_busy;

  // ==========================================================
  // bus answer, one wait state, answer on the second edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & ~ack_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_response <= 2'h0;
    end else begin
      avs_response <= mapped ? 2'h0 : 2'h2;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl0_ff  <= RST_CTL0;
      start_ff <= 1'b0;
    end else if (wr_go && hit_ctl0) begin
      ctl0_ff  <= wdat & MSK_CTL0; // RL6
      start_ff <= wdat[BIT_START]; // RL5
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl1_ff <= RST_CTL1;
    end else if (wr_go && hit_ctl1) begin
      ctl1_ff <= wdat & MSK_CTL1; // RL7 RL8
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl2_ff <= RST_CTL2;
    end else if (wr_go && hit_ctl2) begin
      ctl2_ff <= wdat & MSK_CTL2; // RL10
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bgap_ff <= RST_BGAP;
    end else if (wr_go && hit_bgap) begin
      bgap_ff <= wdat & MSK_BGAP; // RL11
    end
  end

  // ==========================================================
  // converter clock divider
  wire [7:0] div_top = CLK_DIV_BASE << fld_clk; // RL7
  wire       div_end = (div_ff >= div_top - 8'h01);
  // restart at each start so the first trial settles before its tick
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (conv_go || !en) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= div_end ? 8'h00 : div_ff + 8'h01;
      tick_ff <= div_end;
    end
  end

  // ==========================================================
  // input synchronisers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= cmp_in;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 16'h0000;
      pin_s2_ff <= 16'h0000;
    end else begin
      pin_s1_ff <= pin_analog_sel;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ==========================================================
  // sequencer, start on the falling edge of start while enabled
  arc_sar u_sar (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .tick     (tick_ff),
    .go       (conv_go),
    .cmp_hi   (cmp_s2_ff),
    .busy_ff  (sar_busy),
    .done_ff  (sar_done),
    .trial_ff (sar_trial),
    .res_ff   (sar_res)
  );

  // ==========================================================
  // result register, loaded at completion only

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_ff <= RST_RES;
    end else if (sar_done && en) begin
      res_ff <= sar_res; // RL1 RL4 RL16
    end
  end

  // ==========================================================
  // analog routing
  wire        ext_on  = (fld_src == SRC_EXT); // RL14
  wire [15:0] ext_hot = ext_on ? (16'h0001 << fld_chan) : 16'h0000; // RL9
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dac_trial <= 12'h000;
    end else begin
      dac_trial <= sar_trial;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mux_ext_onehot <= 16'h0000;
      mux_int_sel    <= 4'h0;
      mux_ext_on     <= 1'b0;
    end else begin
      mux_ext_onehot <= ext_hot; // RL9 RL14
      mux_int_sel    <= fld_src; // RL8
      mux_ext_on     <= ext_on; // RL14
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_digital_off  <= 16'h0000;
      pin_pullhigh_off <= 16'h0000;
    end else begin
      pin_digital_off  <= pin_s2_ff; // RL12
      pin_pullhigh_off <= pin_s2_ff; // RL13
    end
  end

  // ==========================================================
  // gain amplifier and bandgap copies
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pga_enable    <= 1'b0;
      pga_input_sel <= 1'b0;
      ref_sel       <= 2'h0;
      pga_gain_sel  <= 2'h0;
    end else begin
      pga_enable    <= fld_pga_en; // RL10
      pga_input_sel <= fld_pga_is;
      ref_sel       <= fld_ref;
      pga_gain_sel  <= fld_gain;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bgap_enable <= 1'b0;
    end else begin
      bgap_enable <= fld_bgap; // RL11
    end
  end
endmodule
`default_nettype wire

// [sim/arc_top_chk.sv]
// Purpose: bus handshake and selection checks for arc_top
// Assumes: one clock, nrst asynchronous active low
// Notes:   bound to every arc_top instance
`timescale 1ns/1ps
`default_nettype none
module arc_chk
  import arc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // input selection
  input wire logic [15:0] mux_ext_onehot,
  input wire logic [3:0]  mux_int_sel,
  input wire logic        mux_ext_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // bus handshake
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_unmapped_rsp: assert property (!avs_waitrequest && avs_address > 5'h14
    |-> avs_response == 2'b10 && avs_readdata == 32'h00000000)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (!avs_waitrequest && avs_address <= 5'h14
    && avs_address[1:0] == 2'b00 |-> avs_response == 2'b00)
    else $error("mapped access refused");
  // ==========================================================
  // input selection
  chk_ext_onehot: assert property ($onehot0(mux_ext_onehot))
    else $error("more than one external channel");
  chk_ext_off: assert property (!mux_ext_on |-> mux_ext_onehot == 16'h0000)
    else $error("external channel on while path off");
  chk_int_src: assert property (mux_ext_on |-> mux_int_sel == SRC_EXT)
    else $error("external path on with internal source");
endmodule

bind arc_top arc_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .mux_ext_onehot(mux_ext_onehot), .mux_int_sel(mux_int_sel),
  .mux_ext_on(mux_ext_on)
);
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: self-checking bench for arc_top
// Assumes: comparator model keeps a trial bit while trial <= target
// Notes:   clock select 3 keeps conversions short
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import arc_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cmp_in = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'h1, mux_int_sel;
  logic [15:0] pin_analog_sel = 16'h0000, mux_ext_onehot, pin_digital_off, pin_pullhigh_off;
  logic [11:0] dac_trial, tgt = 12'h000;
  logic [1:0]  avs_response, r, ref_sel, pga_gain_sel;
  logic        avs_waitrequest, mux_ext_on, pga_enable, pga_input_sel, bgap_enable;
  int          n_fail = 0, n_compared = 0;
  // ==========================================================
  // clock, comparator, device
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cmp_in <= (dac_trial <= tgt);
  arc_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .cmp_in(cmp_in),
    .pin_analog_sel(pin_analog_sel), .dac_trial(dac_trial), .mux_ext_onehot(mux_ext_onehot),
    .mux_int_sel(mux_int_sel), .mux_ext_on(mux_ext_on), .pin_digital_off(pin_digital_off),
    .pin_pullhigh_off(pin_pullhigh_off), .pga_enable(pga_enable),
    .pga_input_sel(pga_input_sel), .ref_sel(ref_sel), .pga_gain_sel(pga_gain_sel),
    .bgap_enable(bgap_enable));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic start(input logic [11:0] t, input logic [7:0] c);
    tgt <= t;
    wr(OFS_CTL0, c | 8'hA0);
    wr(OFS_CTL0, c | 8'h20);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      bus(1'b0, OFS_CTL0, 8'h00);
      k++;
    end while (q[BIT_BUSY] !== 1'b0 && k < 300);
    chk({31'h0, q[BIT_BUSY]}, 32'h0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(5'(i * 4), 32'h0);
    rd(5'h18, 32'h0);
    chk({30'h0, r}, 32'h2);
  endtask
  task automatic t_regs();
    wr(OFS_CTL1, 8'hFF);
    rd(OFS_CTL1, 32'hF7);
    wr(OFS_CTL2, 8'hF6);
    rd(OFS_CTL2, 32'h96);
    chk({26'h0, pga_enable, pga_input_sel, ref_sel, pga_gain_sel}, 32'h36);
    wr(OFS_BGAP, 8'hFF);
    rd(OFS_BGAP, 32'h01);
    chk({31'h0, bgap_enable}, 32'h1);
    wr(OFS_RES_LO, 8'hFF);
    rd(OFS_RES_LO, 32'h0);
  endtask
  task automatic t_mux();
    wr(OFS_CTL1, 8'h03);
    wr(OFS_CTL0, 8'h0F);
    repeat (2) @(posedge clk_sys);
    chk({11'h0, mux_int_sel, mux_ext_on, mux_ext_onehot}, 32'h00018000);
    wr(OFS_CTL1, 8'h93);
    repeat (2) @(posedge clk_sys);
    chk({11'h0, mux_int_sel, mux_ext_on, mux_ext_onehot}, 32'h00120000);
    wr(OFS_CTL1, 8'h03);
  endtask
  task automatic t_pins();
    pin_analog_sel <= 16'hA5A5;
    repeat (6) @(posedge clk_sys);
    chk({pin_digital_off, pin_pullhigh_off}, 32'hA5A5A5A5);
  endtask
  task automatic t_conv();
    start(12'hA5C, 8'h00);
    rd(OFS_CTL0, 32'h60);
    rd(OFS_RES_HI, 32'h0);
    wait_done();
    rd(OFS_RES_HI, 32'hA5);
    rd(OFS_RES_LO, 32'hC0);
    wr(OFS_CTL0, 8'h30);
    rd(OFS_RES_HI, 32'h0A);
    rd(OFS_RES_LO, 32'h5C);
    start(12'h3F1, 8'h10);
    wait_done();
    rd(OFS_RES_LO, 32'hF1);
    start(12'h123, 8'h10);
    wr(OFS_CTL0, 8'h10);
    repeat (300) @(posedge clk_sys);
    rd(OFS_RES_HI, 32'h03);
    rd(OFS_RES_LO, 32'hF1);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_mux();
    t_pins();
    t_conv();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
